// ==== src/rtc_level_sync.sv ====
// two-stage synchroniser for a level arriving from outside the clock
`timescale 1ns/1ps
`default_nettype none
module rtc_level_sync
    import rtc_regs_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_level,
    output logic      sync_level
);
    logic meta_stage;

    // meta_stage is read by sync_level only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_stage <= 1'b0;
            sync_level <= 1'b0;
        end else begin
            meta_stage <= async_level;
            sync_level <= meta_stage;
        end
    end
endmodule : rtc_level_sync
`default_nettype wire

// ==== src/rtc_reg_store.sv ====
// sixteen-word register store with registered read data
`timescale 1ns/1ps
`default_nettype none
module rtc_reg_store
    import rtc_regs_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = 16
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] words [DEPTH];

    initial begin
        if (DEPTH < 2) $error("rtc_reg_store: DEPTH too small");
    end

    // contents are undefined after power-up, so no reset on the array
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            words[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= words[rd_addr];
        end
    end
endmodule : rtc_reg_store
`default_nettype wire

// ==== src/rtc_register_map.sv ====
// register map of the real-time clock with halt flag and control fields
`timescale 1ns/1ps
`default_nettype none
module rtc_register_map
    import rtc_regs_pkg::*;
#(
    parameter int REG_W = DATA_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             osc_stopped,
    input  wire logic [3:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [REG_W-1:0] reg_wdata,
    input  wire logic             reg_rd,
    output logic      [REG_W-1:0] reg_rdata,
    output logic                  reg_rvalid,
    input  wire logic             periodic_event,
    input  wire logic             first_alarm_match,
    input  wire logic             second_alarm_match,
    output logic                  seconds_round_cmd,
    output logic                  osc_halt_flag,
    output logic                  crystal_select,
    output logic      [6:0]       trim_value,
    output logic                  first_alarm_enable,
    output logic                  second_alarm_enable,
    output logic                  route_select_hi,
    output logic                  route_select_lo,
    output logic                  test_mode,
    output logic                  cycle_select_2,
    output logic                  cycle_select_1,
    output logic                  cycle_select_0,
    output logic                  hour_format_24,
    output logic                  clock_out_control,
    output logic                  periodic_flag,
    output logic                  first_alarm_flag,
    output logic                  second_alarm_flag,
    output logic                  irq_pin_one_n,
    output logic                  irq_pin_two_n
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    initial begin
        if (REG_W != DATA_W) $error("rtc_register_map: REG_W must be 8");
    end

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // implemented bits of each address; everything else reads zero
    function automatic logic [7:0] valid_mask(input logic [3:0] addr);
        case (addr)
            ADDR_SECONDS:     valid_mask = MASK_SECONDS;
            ADDR_MINUTES:     valid_mask = MASK_MINUTES;
            ADDR_HOURS:       valid_mask = MASK_HOURS;
            ADDR_WEEKDAY:     valid_mask = MASK_WEEKDAY;
            ADDR_DATE:        valid_mask = MASK_DATE;
            ADDR_MONTH:       valid_mask = MASK_MONTH;
            ADDR_A1_MINUTE:   valid_mask = MASK_MINUTES;
            ADDR_A1_HOUR:     valid_mask = MASK_HOURS;
            ADDR_A1_WEEKDAYS: valid_mask = MASK_WEEKDAYS;
            ADDR_A2_MINUTE:   valid_mask = MASK_MINUTES;
            ADDR_A2_HOUR:     valid_mask = MASK_HOURS;
            ADDR_A2_WEEKDAYS: valid_mask = MASK_WEEKDAYS;
            ADDR_FORMAT_FLAG: valid_mask = MASK_FORMAT;
            default:          valid_mask = MASK_FULL;
        endcase
    endfunction : valid_mask

    // addresses whose contents are decimal digits
    function automatic logic is_bcd(input logic [3:0] addr);
        case (addr)
            ADDR_SECONDS, ADDR_MINUTES, ADDR_HOURS,
            ADDR_DATE, ADDR_MONTH, ADDR_YEAR,
            ADDR_A1_MINUTE, ADDR_A1_HOUR,
            ADDR_A2_MINUTE, ADDR_A2_HOUR: is_bcd = 1'b1;
            default:                      is_bcd = 1'b0;
        endcase
    endfunction : is_bcd

    // a nibble above nine saturates to nine
    function automatic logic [3:0] digit_limit(input logic [3:0] nib);
        digit_limit = (nib > BCD_MAX) ? BCD_MAX : nib;
    endfunction : digit_limit

    // ****************************************************************
    // write path decode
    // ****************************************************************
    logic [7:0] masked_wdata;
    logic [7:0] store_wdata;
    logic       store_wr;
    logic       trim_wr;
    logic       ctrl1_wr;
    logic       ctrl2_wr;

    assign masked_wdata = reg_wdata & valid_mask(reg_addr);
    assign store_wdata  = is_bcd(reg_addr)
                        ? {digit_limit(masked_wdata[7:4]),
                           digit_limit(masked_wdata[3:0])}
                        : masked_wdata;
    assign trim_wr  = reg_wr && (reg_addr == ADDR_RATE_TRIM);
    assign ctrl1_wr = reg_wr && (reg_addr == ADDR_ALARM_IRQ);
    assign ctrl2_wr = reg_wr && (reg_addr == ADDR_FORMAT_FLAG);
    assign store_wr = reg_wr && !trim_wr && !ctrl1_wr && !ctrl2_wr;

    // ****************************************************************
    // oscillator halt detection
    // ****************************************************************
    logic osc_stopped_sync;

    rtc_level_sync u_halt_sync (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .async_level (osc_stopped),
        .sync_level  (osc_stopped_sync)
    );

    // a stop that coincides with the clearing write keeps the flag set
    logic next_halt;

    assign next_halt = osc_stopped_sync
                     || (osc_halt_flag && !ctrl2_wr);

    // reset stands for power-up from zero volts, so the flag starts set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_halt_flag <= 1'b1;
        end else begin
            osc_halt_flag <= next_halt;
        end
    end

    // ****************************************************************
    // seconds adjust command
    // ****************************************************************
    logic next_round;

    assign next_round = ctrl2_wr && reg_wdata[C2_HALT_ADJ];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seconds_round_cmd <= 1'b0;
        end else begin
            seconds_round_cmd <= next_round;
        end
    end

    // ****************************************************************
    // rate trim register
    // ****************************************************************
    logic [7:0] rate_trim;
    logic [7:0] next_rate_trim;

    assign next_rate_trim = next_halt ? RESET_ZERO
                          : trim_wr   ? reg_wdata
                          : rate_trim;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_trim <= RESET_ZERO;
        end else begin
            rate_trim <= next_rate_trim;
        end
    end

    assign crystal_select = rate_trim[TRIM_XSEL];
    assign trim_value     = rate_trim[6:0];

    // ****************************************************************
    // alarm_irq_control
    // ****************************************************************
    logic [7:0] alarm_irq_control;
    logic [7:0] next_ctrl1;

    // the whole register is forced, so it reads zero while halted
    assign next_ctrl1 = next_halt ? RESET_ZERO
                      : ctrl1_wr  ? reg_wdata
                      : alarm_irq_control;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alarm_irq_control <= RESET_ZERO;
        end else begin
            alarm_irq_control <= next_ctrl1;
        end
    end

    assign first_alarm_enable  = alarm_irq_control[C1_FIRST_EN];
    assign second_alarm_enable = alarm_irq_control[C1_SECOND_EN];
    assign route_select_hi     = alarm_irq_control[C1_ROUTE_HI];
    assign route_select_lo     = alarm_irq_control[C1_ROUTE_LO];
    assign test_mode           = alarm_irq_control[C1_TEST];
    assign cycle_select_2      = alarm_irq_control[C1_CYCLE_HI];
    assign cycle_select_1      = alarm_irq_control[C1_CYCLE_HI-1];
    assign cycle_select_0      = alarm_irq_control[C1_CYCLE_HI-2];

    // ****************************************************************
    // format_flag_control
    // ****************************************************************
    logic next_format;
    logic next_clk_out;
    logic next_periodic;
    logic next_first_fg;
    logic next_second_fg;
    logic first_hit;
    logic second_hit;

    // a match only counts while its enable is set
    assign first_hit  = first_alarm_match && first_alarm_enable;
    assign second_hit = second_alarm_match && second_alarm_enable;

    assign next_format  = ctrl2_wr ? reg_wdata[C2_HOUR_24]
                                   : hour_format_24;
    assign next_clk_out = next_halt ? 1'b0
                        : ctrl2_wr  ? reg_wdata[C2_CLK_OUT]
                        : clock_out_control;

    // events win over a clearing write in the same cycle
    assign next_periodic  = periodic_event
                          || (ctrl2_wr ? reg_wdata[C2_PERIODIC]
                                       : periodic_flag);
    assign next_first_fg  = first_hit
                          || (ctrl2_wr ? reg_wdata[C2_FIRST_FG]
                                       : first_alarm_flag);
    assign next_second_fg = second_hit
                          || (ctrl2_wr ? reg_wdata[C2_SECOND_FG]
                                       : second_alarm_flag);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hour_format_24    <= 1'b0;
            clock_out_control <= 1'b0;
            periodic_flag     <= 1'b0;
            first_alarm_flag  <= 1'b0;
            second_alarm_flag <= 1'b0;
        end else begin
            hour_format_24    <= next_format;
            clock_out_control <= next_clk_out;
            periodic_flag     <= next_periodic;
            first_alarm_flag  <= next_first_fg;
            second_alarm_flag <= next_second_fg;
        end
    end

    // bit4 reads the halt flag, never the adjust value written there
    logic [7:0] format_flag_control;

    assign format_flag_control = {2'b00,
                                  hour_format_24,
                                  osc_halt_flag,
                                  clock_out_control,
                                  periodic_flag,
                                  first_alarm_flag,
                                  second_alarm_flag};

    // ****************************************************************
    // interrupt pin routing
    // ****************************************************************
    // second alarm and periodic move to pin two as the route bits rise;
    // a host of the single-pin variant leaves both bits zero
    logic second_on_two;
    logic periodic_on_two;
    logic next_pin_one;
    logic next_pin_two;

    assign second_on_two   = route_select_lo;
    assign periodic_on_two = route_select_hi;
    assign next_pin_one = (first_alarm_flag && first_alarm_enable)
                        || (second_alarm_flag && second_alarm_enable
                            && !second_on_two)
                        || (periodic_flag && !periodic_on_two);
    assign next_pin_two = (second_alarm_flag && second_alarm_enable
                           && second_on_two)
                        || (periodic_flag && periodic_on_two);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_pin_one_n <= 1'b1;
            irq_pin_two_n <= 1'b1;
        end else begin
            irq_pin_one_n <= !next_pin_one;
            irq_pin_two_n <= !next_pin_two;
        end
    end

    // ****************************************************************
    // register store for time, calendar and alarm words
    // ****************************************************************
    logic [7:0] store_rdata;

    rtc_reg_store #(
        .WIDTH (DATA_W),
        .DEPTH (16)
    ) u_store (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (store_wr),
        .wr_addr (reg_addr),
        .wr_data (store_wdata),
        .rd_addr (reg_addr),
        .rd_data (store_rdata)
    );

    // ****************************************************************
    // read path
    // ****************************************************************
    // two-stage read keeps the answer on a flop after the store's
    // own registered output; costs one cycle of latency
    logic [3:0] rd_addr_q;
    logic       rd_pend;
    logic [7:0] ctrl_rd_q;
    logic [7:0] ctrl_rd_sel;
    logic [7:0] next_rdata;

    assign ctrl_rd_sel = (reg_addr == ADDR_RATE_TRIM) ? rate_trim
                       : (reg_addr == ADDR_ALARM_IRQ) ? alarm_irq_control
                       : format_flag_control;

    assign next_rdata =
        ((rd_addr_q == ADDR_RATE_TRIM) || (rd_addr_q == ADDR_ALARM_IRQ)
         || (rd_addr_q == ADDR_FORMAT_FLAG))
        ? ctrl_rd_q
        : (store_rdata & valid_mask(rd_addr_q));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_addr_q <= 4'h0;
            rd_pend   <= 1'b0;
            ctrl_rd_q <= RESET_ZERO;
        end else begin
            rd_addr_q <= reg_addr;
            rd_pend   <= reg_rd;
            ctrl_rd_q <= ctrl_rd_sel;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= RESET_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_pend;
            if (rd_pend) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule : rtc_register_map
`default_nettype wire

// ==== src/rtc_regs_pkg.sv ====
// register map constants for the real-time clock register block
package rtc_regs_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // ****************************************************************
    // internal addresses
    // ****************************************************************
    localparam logic [3:0] ADDR_SECONDS      = 4'h0;
    localparam logic [3:0] ADDR_MINUTES      = 4'h1;
    localparam logic [3:0] ADDR_HOURS        = 4'h2;
    localparam logic [3:0] ADDR_WEEKDAY      = 4'h3;
    localparam logic [3:0] ADDR_DATE         = 4'h4;
    localparam logic [3:0] ADDR_MONTH        = 4'h5;
    localparam logic [3:0] ADDR_YEAR         = 4'h6;
    localparam logic [3:0] ADDR_RATE_TRIM    = 4'h7;
    localparam logic [3:0] ADDR_A1_MINUTE    = 4'h8;
    localparam logic [3:0] ADDR_A1_HOUR      = 4'h9;
    localparam logic [3:0] ADDR_A1_WEEKDAYS  = 4'hA;
    localparam logic [3:0] ADDR_A2_MINUTE    = 4'hB;
    localparam logic [3:0] ADDR_A2_HOUR      = 4'hC;
    localparam logic [3:0] ADDR_A2_WEEKDAYS  = 4'hD;
    localparam logic [3:0] ADDR_ALARM_IRQ    = 4'hE;
    localparam logic [3:0] ADDR_FORMAT_FLAG  = 4'hF;

    // ****************************************************************
    // implemented bits per register
    // ****************************************************************
    localparam logic [7:0] MASK_SECONDS   = 8'h7F;
    localparam logic [7:0] MASK_MINUTES   = 8'h7F;
    localparam logic [7:0] MASK_HOURS     = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY   = 8'h07;
    localparam logic [7:0] MASK_DATE      = 8'h3F;
    localparam logic [7:0] MASK_MONTH     = 8'h1F;
    localparam logic [7:0] MASK_FULL      = 8'hFF;
    localparam logic [7:0] MASK_WEEKDAYS  = 8'h7F;
    localparam logic [7:0] MASK_FORMAT    = 8'h3F;

    // ****************************************************************
    // alarm_irq_control field positions
    // ****************************************************************
    localparam int C1_FIRST_EN  = 7;
    localparam int C1_SECOND_EN = 6;
    localparam int C1_ROUTE_HI  = 5;
    localparam int C1_ROUTE_LO  = 4;
    localparam int C1_TEST      = 3;
    localparam int C1_CYCLE_HI  = 2;

    // ****************************************************************
    // format_flag_control field positions
    // ****************************************************************
    localparam int C2_HOUR_24   = 5;
    localparam int C2_HALT_ADJ  = 4;
    localparam int C2_CLK_OUT   = 3;
    localparam int C2_PERIODIC  = 2;
    localparam int C2_FIRST_FG  = 1;
    localparam int C2_SECOND_FG = 0;

    // ****************************************************************
    // rate_trim field position, shared reset value and other constants
    // ****************************************************************
    localparam int TRIM_XSEL    = 7;
    localparam logic [7:0] RESET_ZERO  = 8'h00;
    localparam logic [3:0] BCD_MAX     = 4'h9;
    localparam int SYNC_STAGES  = 2;
    localparam int READ_LATENCY = 2;

endpackage : rtc_regs_pkg

// ==== tb/rtc_host_model.sv ====
// host model driving the internal register byte port
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
    input  wire logic       sys_clk,
    input  wire logic       reg_rvalid,
    input  wire logic [7:0] reg_rdata,
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // stale data is inverted so nothing leans on a held value
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        d = 8'hXX;
        while (n < 8) begin
            @(posedge sys_clk);
            n++;
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                n = 8;
            end
        end
    endtask : rd
endmodule : rtc_host_model
`default_nettype wire

// ==== tb/rtc_map_properties.sv ====
// concurrent checks on the register map ports
`timescale 1ns/1ps
`default_nettype none
module rtc_map_checker #(
    parameter int REG_W = 8
) (
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic             osc_stopped,
    input wire logic [3:0]       reg_addr,
    input wire logic             reg_wr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic             reg_rd,
    input wire logic             reg_rvalid,
    input wire logic             first_alarm_match,
    input wire logic             seconds_round_cmd,
    input wire logic             osc_halt_flag,
    input wire logic             crystal_select,
    input wire logic [6:0]       trim_value,
    input wire logic             first_alarm_enable,
    input wire logic             clock_out_control,
    input wire logic             first_alarm_flag
);
    wire wr_f = reg_wr && reg_addr == 4'hF;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_read_latency: assert property (reg_rd |-> ##2 reg_rvalid)
        else $error("read answer late");
    chk_read_cause: assert property (reg_rvalid |-> $past(reg_rd, 2))
        else $error("read answer without request");
    chk_halt_forced: assert property (osc_halt_flag && $past(osc_halt_flag)
        |-> !crystal_select && trim_value == 7'h00 && !first_alarm_enable
        && !clock_out_control) else $error("control bit alive while halted");
    chk_halt_clear: assert property (wr_f && !osc_stopped
        && !$past(osc_stopped) && !$past(osc_stopped, 2)
        && !$past(osc_stopped, 3) |=> !osc_halt_flag)
        else $error("halt flag not cleared");
    chk_halt_hold: assert property (osc_halt_flag && !wr_f |=> osc_halt_flag)
        else $error("halt flag dropped");
    chk_halt_set: assert property (osc_stopped [*4] |=> osc_halt_flag)
        else $error("halt flag not set");
    chk_adjust_pulse: assert property (wr_f && reg_wdata[4]
        |=> seconds_round_cmd) else $error("adjust pulse missing");
    chk_adjust_cause: assert property (seconds_round_cmd
        |-> $past(wr_f) && $past(reg_wdata[4])) else $error("stray adjust");
    chk_alarm_on: assert property (first_alarm_match && first_alarm_enable
        |=> first_alarm_flag) else $error("enabled alarm flag missing");
    chk_alarm_off: assert property (!first_alarm_flag && !first_alarm_enable
        && !wr_f |=> !first_alarm_flag) else $error("disabled alarm flagged");
endmodule : rtc_map_checker
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the register map
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s: expected %h seen %h", n, e, g); end end
module tb_top;
    logic sys_clk, rst, osc_stopped, reg_wr, reg_rd, reg_rvalid;
    logic periodic_event, first_alarm_match, second_alarm_match;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic osc_halt_flag, crystal_select, first_alarm_enable, periodic_flag;
    logic first_alarm_flag, second_alarm_flag, irq_pin_one_n, irq_pin_two_n;
    logic hour_format_24;
    logic [6:0] c1_low;
    int fails = 0;
    int checks_done = 0;
    localparam logic [7:0] EXP [16] = '{8'h79, 8'h79, 8'h39, 8'h07, 8'h39,
        8'h19, 8'h99, 8'hFF, 8'h79, 8'h39, 8'h7F, 8'h79, 8'h39, 8'h7F,
        8'hC7, 8'h20};
    rtc_register_map dut (.sys_clk, .rst, .osc_stopped, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .periodic_event,
        .first_alarm_match, .second_alarm_match, .seconds_round_cmd(),
        .osc_halt_flag, .crystal_select, .trim_value(), .first_alarm_enable,
        .second_alarm_enable(c1_low[6]), .route_select_hi(c1_low[5]),
        .route_select_lo(c1_low[4]), .test_mode(c1_low[3]),
        .cycle_select_2(c1_low[2]), .cycle_select_1(c1_low[1]),
        .cycle_select_0(c1_low[0]), .hour_format_24, .clock_out_control(),
        .periodic_flag, .first_alarm_flag, .second_alarm_flag,
        .irq_pin_one_n, .irq_pin_two_n);
    rtc_host_model host (.sys_clk, .reg_rvalid, .reg_rdata, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rd);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        host.rd(a, v);
        `CHK("read data", e, v)
    endtask : rchk
    task automatic pulse(input logic [2:0] ev);
        @(posedge sys_clk);
        {periodic_event, first_alarm_match, second_alarm_match} <= ev;
        @(posedge sys_clk);
        {periodic_event, first_alarm_match, second_alarm_match} <= 3'b000;
        @(posedge sys_clk);
        // pins launch on this edge; look once they have settled
        @(negedge sys_clk);
    endtask : pulse
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_halted();
        `CHK("halt flag", 1'b1, osc_halt_flag)
        rchk(4'hE, 8'h00);
        rchk(4'hF, 8'h10);
        host.wr(4'hE, 8'hFF);
        host.wr(4'h7, 8'hFF);
        rchk(4'hE, 8'h00);
        rchk(4'h7, 8'h00);
        host.wr(4'hF, 8'h20);
        rchk(4'hF, 8'h20);
    endtask : t_halted
    task automatic t_map();
        for (int a = 0; a < 16; a++) host.wr(a[3:0], a > 13 ? EXP[a] : 8'hFF);
        for (int a = 0; a < 16; a++) rchk(a[3:0], EXP[a]);
        `CHK("control-1 pins", 8'hC7, {first_alarm_enable, c1_low})
        for (int a = 0; a < 16; a++) host.wr(a[3:0], 8'h00);
        for (int a = 0; a < 16; a++) rchk(a[3:0], 8'h00);
    endtask : t_map
    task automatic t_flags();
        host.wr(4'hF, 8'h30);
        rchk(4'hF, 8'h20);
        host.wr(4'hE, 8'h80);
        pulse(3'b111);
        `CHK("first alarm flag", 1'b1, first_alarm_flag)
        `CHK("second alarm flag", 1'b0, second_alarm_flag)
        `CHK("periodic flag", 1'b1, periodic_flag)
        `CHK("pin one", 1'b0, irq_pin_one_n)
        `CHK("pin two", 1'b1, irq_pin_two_n)
        rchk(4'hF, 8'h26);
        `CHK("hour format", 1'b1, hour_format_24)
        host.wr(4'hF, 8'h20);
        rchk(4'hF, 8'h20);
    endtask : t_flags
    task automatic t_stop();
        host.wr(4'h7, 8'hFF);
        host.wr(4'hF, 8'h28);
        rchk(4'h7, 8'hFF);
        rchk(4'hF, 8'h28);
        @(posedge sys_clk) osc_stopped <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK("halt flag", 1'b1, osc_halt_flag)
        `CHK("alarm enable", 1'b0, first_alarm_enable)
        `CHK("crystal select", 1'b0, crystal_select)
        rchk(4'hE, 8'h00);
        rchk(4'hF, 8'h30);
        osc_stopped <= 1'b0;
        repeat (4) @(posedge sys_clk);
        host.wr(4'hF, 8'h20);
        rchk(4'h7, 8'h00);
        rchk(4'hF, 8'h20);
    endtask : t_stop
    initial begin
        {rst, osc_stopped, periodic_event} = 3'b100;
        {first_alarm_match, second_alarm_match} = 2'b00;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_halted();
        t_map();
        t_flags();
        t_stop();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        conclude();
    end
endmodule : tb_top
bind rtc_register_map rtc_map_checker #(.REG_W(REG_W)) chk (.sys_clk, .rst,
    .osc_stopped, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rvalid,
    .first_alarm_match, .seconds_round_cmd, .osc_halt_flag, .crystal_select,
    .trim_value, .first_alarm_enable, .clock_out_control, .first_alarm_flag);
`default_nettype wire
